// ==== srt_map_mem.sv ====
// Map memory: one 16-bit entry per (key, logical segment) pair.
// Assumes one write port and one registered read port on the system clock.
`timescale 1ns/10ps
module srt_map_mem
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [SRT_MAP_AW-1:0] wr_addr,
  input wire logic [SRT_ENTRY_W-1:0] wr_data,
  input wire logic [SRT_MAP_AW-1:0] rd_addr,
  output logic [SRT_ENTRY_W-1:0] rd_data
);
  logic [SRT_ENTRY_W-1:0] mem [SRT_MAP_DEPTH];

  // Entries are never reset so that contents survive a disable
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read data
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : srt_map_mem

// ==== srt_pkg.sv ====
// Package for the segment relocation translator: widths, field positions, codes.
// Assumes a single system clock; shared by the translator and its map memory.
package srt_pkg;
  localparam int SRT_KEY_W = 3;
  localparam int SRT_SEG_W = 5;
  localparam int SRT_LADDR_W = 16;
  localparam int SRT_PADDR_W = 24;
  localparam int SRT_ENTRY_W = 16;
  localparam int SRT_BASE_W = 13;
  localparam int SRT_OFS_W = 11;
  localparam int SRT_MAP_DEPTH = 256;
  localparam int SRT_MAP_AW = 8;
  // Entry fields, bit 0 is the least significant (LSB-0 terms, bit 15 is the most significant)
  localparam int SRT_VALID_BIT = 2;
  localparam int SRT_RDONLY_BIT = 1;
  localparam int SRT_BASE_LSB = 3;
  // Status word bits, LSB-0 positions of MSB-first status bits 1 and 3
  localparam int SRT_PSW_ISA_BIT = 14;
  localparam int SRT_PSW_PROT_BIT = 12;
  localparam logic [15:0] SRT_PSW_ZERO = 16'h0000;
  localparam logic [7:0] SRT_PASS_HI = 8'h00;
  localparam logic [2:0] SRT_KEY_ZERO = 3'h0;

  // Privileged operations on the translator
  typedef enum logic [2:0] {
    SRT_OP_NONE = 3'h0,
    SRT_OP_LOAD = 3'h1,
    SRT_OP_READ = 3'h2,
    SRT_OP_ON = 3'h3,
    SRT_OP_OFF = 3'h4
  } srt_op_t;

  // Translation request from the processor or a cycle-steal channel
  typedef struct packed {
    logic valid;
    logic [SRT_LADDR_W-1:0] laddr;
    logic [SRT_KEY_W-1:0] key;
    logic write;
    logic problem_state;
    logic cycle_steal;
    logic dcb_access;
  } srt_req_t;

  // Answer toward storage and the status logic
  typedef struct packed {
    logic valid;
    logic [SRT_PADDR_W-1:0] paddr;
    logic write;
    logic fault;
    logic [15:0] psw_bits;
  } srt_rsp_t;
endpackage : srt_pkg

// ==== srt_requester.sv ====
// Requester model: processor or cycle-steal channel driving the translator.
// Assumes the bench hands it one command per cycle on the system clock.
`timescale 1ns/10ps
module srt_requester
  import srt_pkg::*;
(
  input wire logic clk,
  input wire srt_req_t cmd,
  output srt_req_t req
);
  initial req = '0;
  // Present each command one cycle later; idle address lines keep toggling
  always @(posedge clk) begin
    req <= cmd;
    if (cmd.cycle_steal && cmd.dcb_access) begin
      req.key <= SRT_KEY_ZERO;
    end
    if (!cmd.valid) begin
      req.laddr <= ~req.laddr;
    end
  end
endmodule : srt_requester

// ==== srt_translator.sv ====
// Segment relocation translator: key plus logical address to physical address.
// Assumes requesters hold a request one cycle and sys_rst covers power-on reset.
// Assumes console and load pins stay high for at least two clock cycles.
//
// Notes on behaviour
// - Off means 16-bit pass-through, low 64K only
// - One 32-entry stack per key value
// - Entry holds base of a 2K segment
// - Entries may share identical physical bases
// - Active or I/O key selects stack
// - Logical bits 0-4 select the entry
// - Physical bits 0-12 come from entry
// - Logical bits 5-15 become physical 13-23
// - Invalid entry refuses access, sets status
// - Problem-state write to read-only faults, protect
// - Read-only ignored for I/O and supervisor
// - I/O uses same path; key 0 for control
// - Only enable instruction turns translator on
// - Disable, resets, console actions turn it off
// - Off clears control state, keeps map
// - Machine check leaves enable state alone
// - Four privileged ops: load, read, on, off
// - Invalid address indication is status bit 1
// - Protect check is status bit 3
// - Address keys are three bits wide
`timescale 1ns/10ps
module srt_translator
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire srt_req_t req,
  input wire logic op_valid,
  input wire srt_op_t op_code,
  input wire logic op_privileged,
  input wire logic [SRT_KEY_W-1:0] op_key,
  input wire logic [SRT_SEG_W-1:0] op_seg,
  input wire logic [SRT_ENTRY_W-1:0] op_wdata,
  input wire logic check_restart,
  input wire logic initial_program_load,
  input wire logic console_reset,
  input wire logic machine_check,
  output srt_rsp_t rsp,
  output logic [SRT_ENTRY_W-1:0] op_rdata,
  output logic op_rdata_valid,
  output logic op_priv_fault,
  output logic xlate_on
);
  typedef enum logic [1:0] {
    SRT_ST_OFF = 2'b01,
    SRT_ST_ON = 2'b10
  } srt_state_t;

  srt_state_t state_q;
  srt_state_t state_d;
  logic off_event;
  logic op_ok;
  logic [SRT_KEY_W-1:0] key_eff;
  logic [SRT_MAP_AW-1:0] rd_addr;
  logic [SRT_MAP_AW-1:0] wr_addr;
  logic [SRT_ENTRY_W-1:0] entry;
  srt_req_t req_q;
  logic read_pend_q;
  logic entry_valid;
  logic entry_ro;
  logic ro_applies;
  logic fault_isa;
  logic fault_prot;
  logic [15:0] psw_d;
  logic [SRT_PADDR_W-1:0] paddr_d;
  logic rsp_valid_q;
  logic rsp_fault_q;
  logic rsp_write_q;
  logic [SRT_PADDR_W-1:0] rsp_paddr_q;
  logic [15:0] rsp_psw_q;
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_rise;
  logic pin_off;

  // Privileged ops only take effect in supervisor state
  assign op_ok = op_valid && op_privileged;

  // Console keys and load request arrive from outside the clock domain
  assign pin_raw = {check_restart, initial_program_load, console_reset};

  // Three synchroniser flops and a level flop per pin; a level counts once the second and third agree
  for (genvar g = 0; g < NPIN; g++) begin : g_pin_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // Synchroniser chain; only the second flop reads the first
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end else begin
        s1_q <= pin_raw[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end

    // Filtered level; a lone glitch never reaches it
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        lvl_q <= 1'b0;
      end else if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end

    // One disable per press, on the agreed rising level
    assign pin_rise[g] = (s2_q == s3_q) && s3_q && !lvl_q;
  end

  // Any console or load press
  assign pin_off = |pin_rise;

  // Every disabling source; machine check is not among them
  assign off_event = sys_rst || pin_off
                     || (op_ok && op_code == SRT_OP_OFF);

  // Enable state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SRT_ST_OFF: begin
        if (op_ok && op_code == SRT_OP_ON && !off_event) begin
          state_d = SRT_ST_ON;
        end
      end
      SRT_ST_ON: begin
        if (off_event) begin
          state_d = SRT_ST_OFF;
        end
      end
      default: begin
        state_d = SRT_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= SRT_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Channel control fetches always use key zero
  assign key_eff = (req.cycle_steal && req.dcb_access) ? SRT_KEY_ZERO : req.key;

  // Stack index is the key, entry index the top five address bits
  assign rd_addr = op_ok && op_code == SRT_OP_READ ? {op_key, op_seg}
                   : {key_eff, req.laddr[SRT_LADDR_W-1 -: SRT_SEG_W]};
  assign wr_addr = {op_key, op_seg};

  // Map storage; shared bases are allowed, nothing checks uniqueness
  srt_map_mem u_map (
    .clk(clk),
    .wr_en(op_ok && op_code == SRT_OP_LOAD),
    .wr_addr(wr_addr),
    .wr_data(op_wdata),
    .rd_addr(rd_addr),
    .rd_data(entry)
  );

  // Request pipeline stage, aligned with the map read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_q <= '0;
    end else begin
      req_q <= req;
    end
  end

  // A copy-out is pending while its entry is being read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      read_pend_q <= 1'b0;
    end else begin
      read_pend_q <= op_ok && op_code == SRT_OP_READ;
    end
  end

  // Entry decode
  assign entry_valid = entry[SRT_VALID_BIT];
  assign entry_ro = entry[SRT_RDONLY_BIT];
  assign ro_applies = req_q.write && req_q.problem_state && !req_q.cycle_steal;
  assign fault_isa = (state_q == SRT_ST_ON) && !entry_valid;
  assign fault_prot = (state_q == SRT_ST_ON) && entry_valid && entry_ro && ro_applies;

  // Physical address formation
  always_comb begin
    psw_d = SRT_PSW_ZERO;
    if (state_q == SRT_ST_ON) begin
      paddr_d = {entry[SRT_ENTRY_W-1 -: SRT_BASE_W],
                 req_q.laddr[SRT_OFS_W-1:0]};
    end else begin
      paddr_d = {SRT_PASS_HI, req_q.laddr};
    end
    psw_d[SRT_PSW_ISA_BIT] = fault_isa;
    psw_d[SRT_PSW_PROT_BIT] = fault_prot;
  end

  // Storage strobe; faulted requests carry none
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= req_q.valid && !fault_isa && !fault_prot;
    end
  end

  // Fault flag toward the interrupt logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_fault_q <= 1'b0;
    end else begin
      rsp_fault_q <= req_q.valid && (fault_isa || fault_prot);
    end
  end

  // Physical address; only meaningful with the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_paddr_q <= '0;
    end else begin
      rsp_paddr_q <= paddr_d;
    end
  end

  // Write qualifier; a protect fault leaves storage unmodified
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_write_q <= 1'b0;
    end else begin
      rsp_write_q <= req_q.write && !fault_prot;
    end
  end

  // Status word bits, only for a real request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_psw_q <= SRT_PSW_ZERO;
    end else begin
      rsp_psw_q <= req_q.valid ? psw_d : SRT_PSW_ZERO;
    end
  end

  // Answer bundle toward storage and the status logic
  assign rsp = '{valid: rsp_valid_q, paddr: rsp_paddr_q, write: rsp_write_q,
                 fault: rsp_fault_q, psw_bits: rsp_psw_q};

  // Copy-out of an entry; data holds until the next copy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_rdata <= '0;
      op_rdata_valid <= 1'b0;
    end else begin
      op_rdata_valid <= read_pend_q;
      if (read_pend_q) begin
        op_rdata <= entry;
      end
    end
  end

  // Refusal of an op tried outside supervisor state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_priv_fault <= 1'b0;
    end else begin
      op_priv_fault <= op_valid && !op_privileged && op_code != SRT_OP_NONE;
    end
  end

  // Enable level as seen from outside
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xlate_on <= 1'b0;
    end else begin
      xlate_on <= (state_d == SRT_ST_ON);
    end
  end
endmodule : srt_translator

// ==== srt_translator_assertions.sv ====
// Checker on the translator ports: answer timing, faults, enable state.
// Assumes it is bound to every srt_translator instance.
`timescale 1ns/10ps
module srt_assertions
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire srt_req_t req,
  input wire logic op_valid,
  input wire srt_op_t op_code,
  input wire logic op_privileged,
  input wire logic check_restart,
  input wire logic initial_program_load,
  input wire logic console_reset,
  input wire srt_rsp_t rsp,
  input wire logic op_priv_fault,
  input wire logic xlate_on
);
  logic go_on, go_off, ro_hit, pins;
  logic [2:0] quiet_q;
  // Decoded enable, disable and protected-write events
  assign go_on = op_valid && op_privileged && op_code == SRT_OP_ON;
  assign go_off = op_valid && op_privileged && op_code == SRT_OP_OFF;
  assign pins = check_restart || initial_program_load || console_reset;
  // Cycles since a console or load pin was last high; the filter has settled at 7
  always_ff @(posedge clk) begin
    if (sys_rst || pins) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  assign ro_hit = req.valid && req.write && req.problem_state && !req.cycle_steal;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_pass; !xlate_on && req.valid |-> ##2 rsp.valid && rsp.paddr == {SRT_PASS_HI, $past(req.laddr, 2)}; endproperty
  a_pass: assert property (p_pass) else $error("pass-through wrong");
  property p_ofs; req.valid |-> ##2 rsp.fault || rsp.paddr[10:0] == $past(req.laddr[10:0], 2); endproperty
  a_ofs: assert property (p_ofs) else $error("offset wrong");
  property p_gate; rsp.fault |-> !rsp.valid && (rsp.psw_bits[SRT_PSW_ISA_BIT] || rsp.psw_bits[SRT_PSW_PROT_BIT]); endproperty
  a_gate: assert property (p_gate) else $error("fault gating wrong");
  property p_idle; !req.valid |-> ##2 !rsp.valid && !rsp.fault; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_on; $rose(xlate_on) |-> $past(go_on); endproperty
  a_on: assert property (p_on) else $error("enabled without enable op");
  property p_off; go_off |=> !xlate_on; endproperty
  a_off: assert property (p_off) else $error("not disabled");
  property p_pin; $rose(pins) ##1 pins |-> ##[1:4] !xlate_on; endproperty
  a_pin: assert property (p_pin) else $error("console event did not disable");
  property p_hold; xlate_on && !go_off && quiet_q == 3'h7 |=> xlate_on; endproperty
  a_hold: assert property (p_hold) else $error("enable lost");
  property p_priv; op_valid && !op_privileged |=> op_priv_fault; endproperty
  a_priv: assert property (p_priv) else $error("no privilege fault");
  property p_ro; rsp.psw_bits[SRT_PSW_PROT_BIT] |-> $past(ro_hit, 2); endproperty
  a_ro: assert property (p_ro) else $error("protect check wrong");
  c_fault: cover property (rsp.fault);
  c_on: cover property ($rose(xlate_on));
  c_priv: cover property (op_priv_fault);
endmodule : srt_assertions
bind srt_translator srt_assertions srt_assertions_inst (.clk(clk), .sys_rst(sys_rst), .req(req),
  .op_valid(op_valid), .op_code(op_code), .op_privileged(op_privileged),
  .check_restart(check_restart), .initial_program_load(initial_program_load),
  .console_reset(console_reset), .rsp(rsp), .op_priv_fault(op_priv_fault), .xlate_on(xlate_on));

// ==== srt_translator_bench.sv ====
// Bench for the translator: map load and read, on/off, translation, faults.
// Assumes the srt_requester model feeds req and a 250 MHz clock.
`timescale 1ns/10ps
module srt_translator_bench;
  import srt_pkg::*;
  logic clk, sys_rst, op_valid, op_privileged, op_rdata_valid, xlate_on;
  logic op_priv_fault, priv_seen;
  logic [3:0] evt;
  srt_op_t op_code;
  logic [7:0] op_ix;
  logic [15:0] op_wdata, op_rdata;
  srt_req_t cmd, req;
  srt_rsp_t rsp;
  int n_mismatch, total_checks;
  logic [23:0] ld_tab [4] = '{24'h7fd5e4, 24'h00d5e4, 24'h610918, 24'h62f806};
  srt_translator srt_translator_inst (.clk(clk), .sys_rst(sys_rst), .req(req),
    .op_valid(op_valid), .op_code(op_code), .op_privileged(op_privileged),
    .op_key(op_ix[7:5]), .op_seg(op_ix[4:0]), .op_wdata(op_wdata), .check_restart(evt[3]),
    .initial_program_load(evt[2]), .console_reset(evt[1]), .machine_check(evt[0]),
    .rsp(rsp), .op_rdata(op_rdata), .op_rdata_valid(op_rdata_valid),
    .op_priv_fault(op_priv_fault),
    .xlate_on(xlate_on));
  srt_requester srt_requester_inst (.clk(clk), .cmd(cmd), .req(req));
  // One-cycle refusal pulse, delayed so op can still see it on return
  always @(posedge clk) priv_seen <= op_priv_fault;
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Privileged op pulse; returns once a read answer has settled
  task automatic op(input srt_op_t c, input logic p, input logic [7:0] ix, input logic [15:0] d);
    @(posedge clk);
    op_code <= c;
    {op_valid, op_privileged, op_ix, op_wdata} <= {1'b1, p, ix, d};
    @(posedge clk);
    op_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask : op
  // Console or check event, held two cycles for the pin filter
  task automatic pulse(input logic [3:0] e);
    @(posedge clk);
    evt <= e;
    repeat (2) @(posedge clk);
    evt <= 4'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask : pulse
  // One request {laddr, key} with flags {write, problem, steal, control block}
  task automatic xreq(input logic [18:0] ak, input logic [3:0] f, input logic [23:0] ep,
      input logic [15:0] ef);
    @(posedge clk);
    cmd <= {1'b1, ak, f};
    @(posedge clk);
    cmd.valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({rsp.valid, rsp.fault, rsp.psw_bits}, {ef == 16'h0, ef != 16'h0, ef});
    if (ef == 16'h0) chk(rsp.paddr, ep);
  endtask : xreq
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    {n_mismatch, total_checks} = '0;
    {sys_rst, op_valid, op_privileged, evt, op_ix, op_wdata} = {3'h5, 4'h0, 8'h0, 16'h0};
    op_code = SRT_OP_NONE;
    cmd = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(xlate_on, 1'b0);
    xreq({16'hf7a5, 3'h5}, 4'h8, 24'h00f7a5, 16'h0);
    for (int i = 0; i < 4; i++) op(SRT_OP_LOAD, 1'b1, ld_tab[i][23:16], ld_tab[i][15:0]);
    op(SRT_OP_READ, 1'b1, 8'h62, 16'h0);
    chk({op_rdata_valid, op_rdata}, 17'h1f806);
    op(SRT_OP_ON, 1'b0, 8'h0, 16'h0);
    chk(xlate_on, 1'b0);
    chk(priv_seen, 1'b1);
    op(SRT_OP_ON, 1'b1, 8'h0, 16'h0);
    chk(xlate_on, 1'b1);
    chk(priv_seen, 1'b0);
    xreq({16'hffff, 3'h3}, 4'h4, 24'hd5e7ff, 16'h0);
    xreq({16'h0123, 3'h6}, 4'h3, 24'hd5e123, 16'h0);
    xreq({16'h0800, 3'h3}, 4'h0, 24'h0, 16'h1 << SRT_PSW_ISA_BIT);
    xreq({16'h1004, 3'h3}, 4'hc, 24'h0, 16'h1 << SRT_PSW_PROT_BIT);
    xreq({16'h1004, 3'h3}, 4'h8, 24'hf80004, 16'h0);
    xreq({16'h1004, 3'h3}, 4'he, 24'hf80004, 16'h0);
    pulse(4'h1);
    chk(xlate_on, 1'b1);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) op(SRT_OP_OFF, 1'b1, 8'h0, 16'h0);
      else pulse(4'h8 >> i);
      chk(xlate_on, 1'b0);
      xreq({16'hffff, 3'h3}, 4'h4, 24'h00ffff, 16'h0);
      op(SRT_OP_ON, 1'b1, 8'h0, 16'h0);
    end
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(xlate_on, 1'b0);
    op(SRT_OP_ON, 1'b1, 8'h0, 16'h0);
    xreq({16'hffff, 3'h3}, 4'h4, 24'hd5e7ff, 16'h0);
    tally_and_finish();
  end
endmodule : srt_translator_bench
